// ==== design/clock_output_power_pkg.sv ====
// Constants shared by the power and clock output control block.
// Assumes a 100 MHz system clock and a 16 MHz reference on a pin.
package clock_output_power_pkg;

   // ==========================================================
   // Register offsets on the serial host port
   localparam logic [5:0] power_mode_control_offset = 6'h07;
   localparam logic [5:0] transmit_amp_enable_offset = 6'h08;
   localparam logic [5:0] misc_control_offset = 6'h09;
   localparam logic [5:0] clock_output_control_offset = 6'h0a;

   // ==========================================================
   // Field positions
   localparam int timed_sleep_bit = 0;
   localparam int deep_sleep_bit = 1;
   localparam int clock_keep_in_sleep_bit = 9;
   localparam int miso_hiz_bit = 11;
   localparam int transmit_amp_bit = 15;
   localparam int status_alt_bit = 7;
   localparam int clock_out_enable_bit = 5;
   localparam int timer_prescale_lsb = 0;
   localparam int capacitor_trim_lsb = 8;
   localparam int rate_lsb = 0;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [15:0] power_mode_control_reset = 16'h0800;
   localparam logic [15:0] transmit_amp_enable_reset = 16'h8000;
   localparam logic [15:0] misc_control_reset = 16'h0020;
   localparam logic [15:0] clock_output_control_reset = 16'h7e06;
   localparam logic [15:0] power_mode_control_writable = 16'h8ae3;
   localparam logic [15:0] transmit_amp_enable_writable = 16'h8000;
   localparam logic [15:0] misc_control_writable = 16'h00a7;
   localparam logic [15:0] clock_output_control_writable = 16'hff07;

   // ==========================================================
   // Serial frame layout
   localparam logic [4:0] header_last_bit = 5'h07;
   localparam logic [4:0] data_last_bit = 5'h0f;
   localparam int read_flag_bit = 7;

   typedef enum logic [1:0] {
      spi_idle = 2'b00,
      spi_header = 2'b01,
      spi_data = 2'b10,
      spi_done = 2'b11
   } spi_phase_t;

   // ==========================================================
   // Clock output timing, in reference rising edges per half period
   localparam logic [7:0] sleep_stop_ref_cycles = 8'h80;
   localparam logic [2:0] slowest_fast_rate = 3'h4;
   localparam logic [8:0] half_8mhz = 9'h001;
   localparam logic [8:0] half_4mhz = 9'h002;
   localparam logic [8:0] half_2mhz = 9'h004;
   localparam logic [8:0] half_1mhz = 9'h008;
   localparam logic [8:0] half_62k5 = 9'h080;
   localparam logic [8:0] half_div488 = 9'h0f4;
   localparam logic [8:0] half_div976 = 9'h1e8;

endpackage

// ==== design/clock_output_divider.sv ====
// Reference clock output divider with glitch-free rate changes.
// Assumes reference_clock is a free running 16 MHz pin, well below the system clock.
`timescale 1ns/1ps
module clock_output_divider #(
   parameter int count_width = 9
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic reference_clock,
   input wire logic enable,
   input wire logic [2:0] rate,
   input wire logic timed_sleep,
   input wire logic keep_in_sleep,
   output logic clock_out
);

   if (count_width < 9) begin
      $error("count_width too small for the slowest rate");
   end

   typedef struct packed {
      logic [1:0] ref_sync;
      logic ref_prev;
      logic [count_width-1:0] count;
      logic [count_width-1:0] half;
      logic [7:0] sleep_count;
      logic stopped;
      logic level;
   } divider_state_t;

   divider_state_t cur;
   divider_state_t next;

   // ==========================================================
   // Half period lookup; zero means follow both reference edges
   function automatic logic [count_width-1:0] half_of(input logic [2:0] code);
      logic [8:0] h;
      case (code)
         3'h0: h = 9'h000;
         3'h1: h = clock_output_power_pkg::half_8mhz;
         3'h2: h = clock_output_power_pkg::half_4mhz;
         3'h3: h = clock_output_power_pkg::half_2mhz;
         3'h4: h = clock_output_power_pkg::half_1mhz;
         3'h5: h = clock_output_power_pkg::half_62k5;
         3'h6: h = clock_output_power_pkg::half_div488;
         default: h = clock_output_power_pkg::half_div976;
      endcase
      half_of = count_width'(h);
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic rise;
      logic fall;
      logic tick;
      logic [2:0] eff_rate;
      rise = 1'b0;
      fall = 1'b0;
      tick = 1'b0;
      eff_rate = rate;
      next = cur;
      next.ref_sync = {cur.ref_sync[0], reference_clock};
      next.ref_prev = cur.ref_sync[1];
      rise = cur.ref_sync[1] & ~cur.ref_prev;
      fall = ~cur.ref_sync[1] & cur.ref_prev;
      if (timed_sleep && rate < clock_output_power_pkg::slowest_fast_rate) begin
         eff_rate = clock_output_power_pkg::slowest_fast_rate;
      end
      if (timed_sleep && !keep_in_sleep) begin
         if (rise && cur.sleep_count != clock_output_power_pkg::sleep_stop_ref_cycles) begin
            next.sleep_count = cur.sleep_count + 8'h01;
         end
         if (next.sleep_count == clock_output_power_pkg::sleep_stop_ref_cycles) begin
            next.stopped = 1'b1;
         end
      end else begin
         next.sleep_count = 8'h00;
         next.stopped = 1'b0;
      end
      tick = (cur.half == '0) ? (rise | fall) : rise;
      if (!enable || cur.stopped) begin
         next.level = 1'b0;
         next.count = '0;
         next.half = half_of(eff_rate);
      end else if (tick) begin
         if (cur.half == '0 || cur.count == cur.half - count_width'(1)) begin
            next.level = ~cur.level;
            next.count = '0;
            next.half = half_of(eff_rate);
         end else begin
            next.count = cur.count + count_width'(1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur <= '0;
         cur.half <= half_of(3'h6);
      end else begin
         cur <= next;
      end
   end

   assign clock_out = cur.level;

endmodule // clock_output_divider

// ==== design/clock_output_power_control.sv ====
// Power modes, transmit gating, status pins, timer prescale, trim and clock output.
// Assumes serial host port pins and reference clock are asynchronous to clock.
// Operation
// - Deep sleep bit stops time base
// - Timed sleep bit keeps time base running unless deep sleep bit set
// - Transmit amplifier bit gates transmitter, default on
// - Alternate enable: pin 1 shows out of idle
// - Alternate enable: pin 2 shows result valid
// - Clock output enable, else pin held low
// - Prescale field selects event timer base clock
// - Capacitor trim field resets to 0x7E
// - Rate codes 0-4 give 16 to 1 MHz
// - Code 5 62.5 kHz, code 6 divide 488
// - Code 7 divides reference by 976
// - Without keep bit, stop after 128 cycles
// - Timed sleep allows only 1 MHz or less
`timescale 1ns/1ps
module clock_output_power_control (
   input wire logic clock,
   input wire logic rst,
   input wire logic spi_clock,
   input wire logic spi_select_n,
   input wire logic spi_mosi,
   output logic miso_out,
   output logic miso_oe,
   input wire logic reference_clock,
   input wire logic device_active,
   input wire logic result_valid,
   input wire logic normal_pin_1_out,
   input wire logic normal_pin_1_oe,
   input wire logic normal_pin_2_out,
   input wire logic normal_pin_2_oe,
   output logic general_pin_1_out,
   output logic general_pin_1_oe,
   output logic general_pin_2_out,
   output logic general_pin_2_oe,
   output logic deep_sleep,
   output logic timed_sleep,
   output logic time_base_run,
   output logic transmit_amplifier_enable,
   output logic [2:0] event_timer_prescale,
   output logic [7:0] capacitor_trim,
   output logic clock_out
);

   typedef struct packed {
      logic [1:0] sclk_sync;
      logic [1:0] sel_sync;
      logic [1:0] mosi_sync;
      logic sclk_prev;
      clock_output_power_pkg::spi_phase_t phase;
      logic [4:0] bit_count;
      logic [7:0] header;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic [15:0] power_mode_control;
      logic [15:0] transmit_amp_enable;
      logic [15:0] misc_control;
      logic [15:0] clock_output_control;
      logic miso_out;
      logic miso_oe;
      logic pin_1_out;
      logic pin_1_oe;
      logic pin_2_out;
      logic pin_2_oe;
      logic deep_sleep;
      logic timed_sleep;
      logic time_base_run;
      logic amp_enable;
      logic [2:0] prescale;
      logic [7:0] trim;
   } control_state_t;

   control_state_t cur;
   control_state_t next;

   // ==========================================================
   // Register helpers
   function automatic logic [15:0] merge(input logic [15:0] data, input logic [15:0] mask,
                                         input logic [15:0] dflt);
      merge = (data & mask) | (dflt & ~mask);
   endfunction

   function automatic logic [15:0] read_reg(input control_state_t s, input logic [5:0] addr);
      case (addr)
         clock_output_power_pkg::power_mode_control_offset: read_reg = s.power_mode_control;
         clock_output_power_pkg::transmit_amp_enable_offset: read_reg = s.transmit_amp_enable;
         clock_output_power_pkg::misc_control_offset: read_reg = s.misc_control;
         clock_output_power_pkg::clock_output_control_offset: read_reg = s.clock_output_control;
         default: read_reg = 16'h0000;
      endcase
   endfunction

   // ==========================================================
   // Serial host port and control outputs
   always_comb begin
      logic rise;
      logic fall;
      logic [7:0] hdr;
      logic [15:0] wdata;
      rise = 1'b0;
      fall = 1'b0;
      hdr = 8'h00;
      wdata = 16'h0000;
      next = cur;
      next.sclk_sync = {cur.sclk_sync[0], spi_clock};
      next.sel_sync = {cur.sel_sync[0], spi_select_n};
      next.mosi_sync = {cur.mosi_sync[0], spi_mosi};
      next.sclk_prev = cur.sclk_sync[1];
      rise = cur.sclk_sync[1] & ~cur.sclk_prev;
      fall = ~cur.sclk_sync[1] & cur.sclk_prev;
      if (cur.sel_sync[1]) begin
         next.phase = clock_output_power_pkg::spi_idle;
         next.bit_count = 5'h00;
         next.miso_out = 1'b0;
         next.miso_oe = ~cur.power_mode_control[clock_output_power_pkg::miso_hiz_bit];
      end else begin
         next.miso_oe = 1'b1;
         if (cur.phase == clock_output_power_pkg::spi_idle) begin
            next.phase = clock_output_power_pkg::spi_header;
         end
         if (rise) begin
            case (cur.phase)
               clock_output_power_pkg::spi_header: begin
                  hdr = {cur.header[6:0], cur.mosi_sync[1]};
                  next.header = hdr;
                  next.bit_count = cur.bit_count + 5'h01;
                  if (cur.bit_count == clock_output_power_pkg::header_last_bit) begin
                     next.phase = clock_output_power_pkg::spi_data;
                     next.bit_count = 5'h00;
                     next.shift_out = hdr[clock_output_power_pkg::read_flag_bit] ?
                                      read_reg(cur, hdr[5:0]) : 16'h0000;
                  end
               end
               clock_output_power_pkg::spi_data: begin
                  wdata = {cur.shift_in[14:0], cur.mosi_sync[1]};
                  next.shift_in = wdata;
                  next.bit_count = cur.bit_count + 5'h01;
                  if (cur.bit_count == clock_output_power_pkg::data_last_bit) begin
                     next.phase = clock_output_power_pkg::spi_done;
                     if (!cur.header[clock_output_power_pkg::read_flag_bit]) begin
                        case (cur.header[5:0])
                           clock_output_power_pkg::power_mode_control_offset: begin
                              next.power_mode_control = merge(wdata,
                                 clock_output_power_pkg::power_mode_control_writable,
                                 clock_output_power_pkg::power_mode_control_reset);
                           end
                           clock_output_power_pkg::transmit_amp_enable_offset: begin
                              next.transmit_amp_enable = merge(wdata,
                                 clock_output_power_pkg::transmit_amp_enable_writable,
                                 clock_output_power_pkg::transmit_amp_enable_reset);
                           end
                           clock_output_power_pkg::misc_control_offset: begin
                              next.misc_control = merge(wdata,
                                 clock_output_power_pkg::misc_control_writable,
                                 clock_output_power_pkg::misc_control_reset);
                           end
                           clock_output_power_pkg::clock_output_control_offset: begin
                              next.clock_output_control = merge(wdata,
                                 clock_output_power_pkg::clock_output_control_writable,
                                 clock_output_power_pkg::clock_output_control_reset);
                           end
                           default: begin
                              next.shift_in = wdata;
                           end
                        endcase
                     end
                  end
               end
               default: begin
                  next.bit_count = cur.bit_count;
               end
            endcase
         end else if (fall && cur.phase == clock_output_power_pkg::spi_data) begin
            next.miso_out = cur.shift_out[15];
            next.shift_out = {cur.shift_out[14:0], 1'b0};
         end
      end

      // Power modes and gating
      next.deep_sleep = cur.power_mode_control[clock_output_power_pkg::deep_sleep_bit];
      next.time_base_run = ~cur.power_mode_control[clock_output_power_pkg::deep_sleep_bit];
      next.timed_sleep = cur.power_mode_control[clock_output_power_pkg::timed_sleep_bit];
      next.amp_enable = cur.transmit_amp_enable[clock_output_power_pkg::transmit_amp_bit];
      next.prescale = cur.misc_control[clock_output_power_pkg::timer_prescale_lsb +: 3];
      next.trim = cur.clock_output_control[clock_output_power_pkg::capacitor_trim_lsb +: 8];

      // General pins 1 and 2
      if (cur.misc_control[clock_output_power_pkg::status_alt_bit]) begin
         next.pin_1_out = device_active;
         next.pin_1_oe = 1'b1;
         next.pin_2_out = result_valid;
         next.pin_2_oe = 1'b1;
      end else begin
         next.pin_1_out = normal_pin_1_out;
         next.pin_1_oe = normal_pin_1_oe;
         next.pin_2_out = normal_pin_2_out;
         next.pin_2_oe = normal_pin_2_oe;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cur <= '0;
         cur.sclk_sync <= 2'b00;
         cur.sel_sync <= 2'b11;
         cur.power_mode_control <= clock_output_power_pkg::power_mode_control_reset;
         cur.transmit_amp_enable <= clock_output_power_pkg::transmit_amp_enable_reset;
         cur.misc_control <= clock_output_power_pkg::misc_control_reset;
         cur.clock_output_control <= clock_output_power_pkg::clock_output_control_reset;
         cur.time_base_run <= 1'b1;
         cur.amp_enable <= 1'b1;
         cur.trim <= 8'h7e;
      end else begin
         cur <= next;
      end
   end

   // ==========================================================
   // Clock output divider
   clock_output_divider #(
      .count_width(9)
   ) divider (
      .clock(clock),
      .rst(rst),
      .reference_clock(reference_clock),
      .enable(cur.misc_control[clock_output_power_pkg::clock_out_enable_bit]),
      .rate(cur.clock_output_control[clock_output_power_pkg::rate_lsb +: 3]),
      .timed_sleep(cur.power_mode_control[clock_output_power_pkg::timed_sleep_bit]),
      .keep_in_sleep(cur.power_mode_control[clock_output_power_pkg::clock_keep_in_sleep_bit]),
      .clock_out(clock_out)
   );

   assign miso_out = cur.miso_out;
   assign miso_oe = cur.miso_oe;
   assign general_pin_1_out = cur.pin_1_out;
   assign general_pin_1_oe = cur.pin_1_oe;
   assign general_pin_2_out = cur.pin_2_out;
   assign general_pin_2_oe = cur.pin_2_oe;
   assign deep_sleep = cur.deep_sleep;
   assign timed_sleep = cur.timed_sleep;
   assign time_base_run = cur.time_base_run;
   assign transmit_amplifier_enable = cur.amp_enable;
   assign event_timer_prescale = cur.prescale;
   assign capacitor_trim = cur.trim;

endmodule // clock_output_power_control

// ==== tb/clock_output_power_control_chk.sv ====
// Port checker for the power and clock output control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module clock_output_power_control_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic spi_select_n,
   input wire logic device_active,
   input wire logic result_valid,
   input wire logic normal_pin_1_oe,
   input wire logic general_pin_1_out,
   input wire logic general_pin_1_oe,
   input wire logic general_pin_2_out,
   input wire logic general_pin_2_oe,
   input wire logic deep_sleep,
   input wire logic timed_sleep,
   input wire logic time_base_run,
   input wire logic transmit_amplifier_enable,
   input wire logic [2:0] event_timer_prescale,
   input wire logic [7:0] capacitor_trim,
   input wire logic clock_out
);
   // ==========================================================
   // Phase length helpers
   logic prev_out;
   logic [15:0] run_len;
   logic [1:0] sleep_rises;
   always_ff @(posedge clock) begin
      prev_out <= rst ? 1'b0 : clock_out;
      if (rst || clock_out != prev_out) begin
         run_len <= 16'h0001;
      end else if (run_len != 16'hffff) begin
         run_len <= run_len + 16'h0001;
      end
      if (rst || !timed_sleep) begin
         sleep_rises <= 2'h0;
      end else if (clock_out && !prev_out && sleep_rises != 2'h3) begin
         sleep_rises <= sleep_rises + 2'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================================
   // Properties
   property p_deep_base;
      time_base_run == !deep_sleep;
   endproperty
   a_deep_base: assert property (p_deep_base)
      else $error("time base wrong in deep sleep");
   property p_timed_base;
      timed_sleep && !deep_sleep |-> time_base_run;
   endproperty
   a_timed_base: assert property (p_timed_base)
      else $error("time base stopped in timed sleep");
   property p_reset_vals;
      $past(rst) |-> capacitor_trim == 8'h7e && transmit_amplifier_enable;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("wrong value after reset");
   property p_alt_pins;
      general_pin_1_oe != $past(normal_pin_1_oe) |-> general_pin_2_oe &&
         general_pin_1_out == $past(device_active) && general_pin_2_out == $past(result_valid);
   endproperty
   a_alt_pins: assert property (p_alt_pins)
      else $error("status pins wrong");
   property p_prescale_frame;
      $changed(event_timer_prescale) |-> !$past(spi_select_n, 2);
   endproperty
   a_prescale_frame: assert property (p_prescale_frame)
      else $error("prescale changed outside a frame");
   property p_trim_frame;
      $changed(capacitor_trim) |-> !$past(spi_select_n, 2);
   endproperty
   a_trim_frame: assert property (p_trim_frame)
      else $error("trim changed outside a frame");
   property p_sleep_rate;
      timed_sleep && clock_out && !prev_out && sleep_rises >= 2'h2 |-> run_len >= 16'h002d;
   endproperty
   a_sleep_rate: assert property (p_sleep_rate)
      else $error("clock output too fast in timed sleep");
   property p_low_phase;
      $fell(clock_out) |=> !clock_out [*2];
   endproperty
   a_low_phase: assert property (p_low_phase)
      else $error("runt low phase on clock output");
endmodule // clock_output_power_control_chk

// ==== tb/spi_host_model.sv ====
// Host model driving the serial register port, mode 0, one access per select.
// Assumes the system clock paces its half periods.
`timescale 1ns/1ps
module spi_host_model #(
   parameter int half_cycles = 6
) (
   input wire logic clock,
   input wire logic miso_out,
   input wire logic miso_oe,
   output logic spi_clock,
   output logic spi_select_n,
   output logic spi_mosi
);
   logic miso_seen;
   logic miso_last = 1'b0;
   // Released line shows the inverse of the last value
   assign miso_seen = miso_oe ? miso_out : ~miso_last;
   initial begin
      spi_clock = 1'b0;
      spi_select_n = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic half();
      repeat (half_cycles) @(posedge clock);
      #1;
   endtask
   task automatic xfer(input logic [23:0] frame, output logic [15:0] rdata);
      rdata = 16'h0000;
      spi_select_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_mosi = frame[i];
         half();
         spi_clock = 1'b1;
         rdata = {rdata[14:0], miso_seen};
         miso_last = miso_seen;
         half();
         spi_clock = 1'b0;
      end
      half();
      spi_select_n = 1'b1;
      spi_mosi = ~spi_mosi;
      half();
   endtask
endmodule // spi_host_model

// ==== tb/clock_output_power_control_tb.sv ====
// Self-checking bench for the power and clock output control block.
// Assumes a free running 16 MHz reference and the host model.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module clock_output_power_control_tb;
   logic clock = 1'b0;
   logic reference_clock = 1'b0;
   logic rst, device_active, result_valid, spi_clock, spi_select_n, spi_mosi;
   logic normal_pin_1_out, normal_pin_1_oe, normal_pin_2_out, normal_pin_2_oe;
   logic miso_out, miso_oe, deep_sleep, timed_sleep, time_base_run, clock_out;
   logic general_pin_1_out, general_pin_1_oe, general_pin_2_out, general_pin_2_oe;
   logic transmit_amplifier_enable;
   logic [2:0] event_timer_prescale;
   logic [7:0] capacitor_trim;
   int err_total = 0;
   int total_checks = 0;
   always #5 clock = ~clock;
   always #31.25 reference_clock = ~reference_clock;
   spi_host_model host (.clock(clock), .miso_out(miso_out), .miso_oe(miso_oe),
      .spi_clock(spi_clock), .spi_select_n(spi_select_n), .spi_mosi(spi_mosi));
   clock_output_power_control uut (.clock(clock), .rst(rst), .spi_clock(spi_clock),
      .spi_select_n(spi_select_n), .spi_mosi(spi_mosi), .miso_out(miso_out),
      .miso_oe(miso_oe), .reference_clock(reference_clock), .device_active(device_active),
      .result_valid(result_valid), .normal_pin_1_out(normal_pin_1_out),
      .normal_pin_1_oe(normal_pin_1_oe), .normal_pin_2_out(normal_pin_2_out),
      .normal_pin_2_oe(normal_pin_2_oe), .general_pin_1_out(general_pin_1_out),
      .general_pin_1_oe(general_pin_1_oe), .general_pin_2_out(general_pin_2_out),
      .general_pin_2_oe(general_pin_2_oe), .deep_sleep(deep_sleep),
      .timed_sleep(timed_sleep), .time_base_run(time_base_run),
      .transmit_amplifier_enable(transmit_amplifier_enable),
      .event_timer_prescale(event_timer_prescale), .capacitor_trim(capacitor_trim),
      .clock_out(clock_out));
   // ==========================================================
   // Shared tasks
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      host.xfer({2'b00, a, d}, r);
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      logic [15:0] r;
      host.xfer({2'b10, a, 16'h0000}, r);
      `CHK(r, e)
   endtask
   task automatic wait_rise();
      logic last;
      int i;
      i = 0;
      last = clock_out;
      step(1);
      while (!(clock_out === 1'b1 && last === 1'b0) && i < 8000) begin
         last = clock_out;
         step(1);
         i++;
      end
      if (i >= 8000) begin
         err_total++;
         $display("Error at %0t: no clock output edge", $time);
      end
   endtask
   task automatic measure(output realtime p);
      realtime t0;
      wait_rise();
      wait_rise();
      t0 = $realtime;
      wait_rise();
      p = $realtime - t0;
   endtask
   task automatic count_rises(input int n, output int c);
      logic last;
      c = 0;
      repeat (n) begin
         last = clock_out;
         step(1);
         if (clock_out === 1'b1 && last === 1'b0) c++;
      end
   endtask
   function automatic logic near(input realtime p, input real e);
      return p > e - 25.0 && p < e + 25.0;
   endfunction
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      `CHK(capacitor_trim, 8'h7e)
      `CHK(transmit_amplifier_enable, 1'b1)
      rd(6'h0a, 16'h7e06);
      rd(6'h09, 16'h0020);
      rd(6'h08, 16'h8000);
      rd(6'h07, 16'h0800);
      wr(6'h05, 16'hffff);
      rd(6'h05, 16'h0000);
   endtask
   task automatic t_sleep();
      wr(6'h07, 16'h0002);
      `CHK({deep_sleep, time_base_run, miso_oe}, 3'b101)
      wr(6'h07, 16'h0801);
      `CHK({timed_sleep, deep_sleep, time_base_run, miso_oe}, 4'b1010)
      wr(6'h07, 16'hffff);
      rd(6'h07, 16'h8ae3);
      wr(6'h07, 16'h0800);
   endtask
   task automatic t_amp();
      wr(6'h08, 16'h0000);
      `CHK(transmit_amplifier_enable, 1'b0)
      wr(6'h08, 16'hffff);
      rd(6'h08, 16'h8000);
      `CHK(transmit_amplifier_enable, 1'b1)
   endtask
   task automatic t_prescale();
      for (int i = 0; i < 8; i++) begin
         wr(6'h09, 16'h0020 | 16'(i));
         `CHK(event_timer_prescale, 3'(i))
      end
      wr(6'h09, 16'hffff);
      rd(6'h09, 16'h00a7);
   endtask
   task automatic t_pins();
      device_active = 1'b1;
      step(2);
      `CHK({general_pin_1_out, general_pin_1_oe, general_pin_2_out, general_pin_2_oe}, 4'b1101)
      {device_active, result_valid} = 2'b01;
      step(2);
      `CHK({general_pin_1_out, general_pin_1_oe, general_pin_2_out, general_pin_2_oe}, 4'b0111)
      wr(6'h09, 16'h0020);
      {normal_pin_1_out, normal_pin_1_oe, normal_pin_2_out} = 3'b111;
      step(2);
      `CHK({general_pin_1_out, general_pin_1_oe, general_pin_2_out, general_pin_2_oe}, 4'b1110)
   endtask
   task automatic t_rates();
      int per [8] = '{1, 2, 4, 8, 16, 256, 488, 976};
      realtime p;
      for (int i = 0; i < 8; i++) begin
         wr(6'h0a, 16'h7e00 | 16'(i));
         measure(p);
         `CHK(near(p, per[i] * 62.5), 1'b1)
      end
   endtask
   task automatic t_enable();
      int c;
      realtime p;
      wr(6'h0a, 16'h7e04);
      wr(6'h09, 16'h0000);
      count_rises(300, c);
      `CHK(c == 0 && clock_out === 1'b0, 1'b1)
      wr(6'h09, 16'h0020);
      measure(p);
      `CHK(near(p, 1000.0), 1'b1)
   endtask
   task automatic t_doze();
      int c;
      realtime p;
      wr(6'h07, 16'h0801);
      step(1000);
      count_rises(600, c);
      `CHK(c == 0 && clock_out === 1'b0, 1'b1)
      wr(6'h07, 16'h0a01);
      measure(p);
      `CHK(near(p, 1000.0), 1'b1)
      wr(6'h0a, 16'h7e00);
      measure(p);
      `CHK(near(p, 1000.0), 1'b1)
      wr(6'h0a, 16'h0106);
      `CHK(capacitor_trim, 8'h01)
   endtask
   task automatic end_of_test();
      $display("Checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      {device_active, result_valid} = 2'b00;
      {normal_pin_1_out, normal_pin_1_oe, normal_pin_2_out, normal_pin_2_oe} = 4'h0;
      repeat (6) @(posedge clock);
      #1 rst = 1'b0;
      step(3);
      t_reset();
      t_sleep();
      t_amp();
      t_prescale();
      t_pins();
      t_rates();
      t_enable();
      t_doze();
      end_of_test();
   end
   initial begin
      #900_000;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // clock_output_power_control_tb
bind clock_output_power_control clock_output_power_control_chk chk (.clock(clock), .rst(rst),
   .spi_select_n(spi_select_n), .device_active(device_active), .result_valid(result_valid),
   .normal_pin_1_oe(normal_pin_1_oe), .general_pin_1_out(general_pin_1_out),
   .general_pin_1_oe(general_pin_1_oe), .general_pin_2_out(general_pin_2_out),
   .general_pin_2_oe(general_pin_2_oe), .deep_sleep(deep_sleep), .timed_sleep(timed_sleep),
   .time_base_run(time_base_run), .transmit_amplifier_enable(transmit_amplifier_enable),
   .event_timer_prescale(event_timer_prescale), .capacitor_trim(capacitor_trim),
   .clock_out(clock_out));
